// ==== src/tac_pkg.sv ====
`default_nettype none
package tac_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CNT_W  = 16;
  localparam int FLAG_W = 9;
  localparam int CTRL_W = 11;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_CLK3   = 8'h04;
  localparam logic [7:0] OFF_CLK4   = 8'h08;
  localparam logic [7:0] OFF_MODE3  = 8'h0C;
  localparam logic [7:0] OFF_MODE4  = 8'h10;
  localparam logic [7:0] OFF_FLAGS  = 8'h14;
  localparam logic [7:0] OFF_CNT3   = 8'h18;
  localparam logic [7:0] OFF_CNT4   = 8'h1C;
  localparam logic [7:0] OFF_CC3A   = 8'h20;
  localparam logic [7:0] OFF_CC3B   = 8'h24;
  localparam logic [7:0] OFF_CC3C   = 8'h28;
  localparam logic [7:0] OFF_CC3D   = 8'h2C;
  localparam logic [7:0] OFF_CC4A   = 8'h30;
  localparam logic [7:0] OFF_CC4C   = 8'h34;
  localparam logic [7:0] OFF_DEAD   = 8'h38;
  localparam logic [7:0] OFF_CARR   = 8'h3C;
  localparam logic [7:0] OFF_CARRB  = 8'h40;
  localparam logic [7:0] OFF_CNT2   = 8'h44;
  localparam logic [7:0] OFF_CNT1   = 8'h48;
  localparam logic [7:0] OFF_CC1A   = 8'h4C;
  localparam logic [7:0] OFF_CC1B   = 8'h50;
  localparam logic [7:0] OFF_CC1D   = 8'h54;
  localparam logic [7:0] OFF_CC0    = 8'h58;
  localparam logic [7:0] OFF_CC5    = 8'h5C;

  // Control register fields
  localparam int CTL_RUN3   = 0;
  localparam int CTL_RUN2   = 1;
  localparam int CTL_CASC   = 2;
  localparam int CTL_MODE   = 3;
  localparam int CTL_BTM    = 5;
  localparam int CTL_CLR3   = 6;
  localparam int CTL_CAP1B  = 7;
  localparam int CTL_CAP0   = 8;
  localparam int CTL_BUF1   = 9;
  localparam int CTL_RUN4   = 10;

  // Mode register fields
  localparam int MD_BFA = 0;
  localparam int MD_BFB = 1;

  // Flag register fields
  localparam int FL_OVF  = 0;
  localparam int FL_UDF  = 1;
  localparam int FL_CMPA = 2;
  localparam int FL_CMPC = 3;
  localparam int FL_CMPD = 4;
  localparam int FL_C1A  = 5;
  localparam int FL_C1B  = 6;
  localparam int FL_CAP5 = 7;
  localparam int FL_OVF2 = 8;

  localparam logic [CNT_W-1:0] CNT_MAX  = 16'hFFFF;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] RST_CC   = 16'hFFFF;
  localparam logic [DATA_W-1:0] RD_ZERO = 32'h0000_0000;

  typedef enum logic [1:0] {TAC_NORMAL, TAC_COMPL, TAC_RSYNC, TAC_RSVD} tac_mode_t;
endpackage
`default_nettype wire

// ==== src/tac_timer.sv ====
// What this block does
// - Counter write in access state beats a simultaneous increment.
// - Compare register write completes and the coincident match still fires.
// - Match-driven buffer transfer moves the buffer value from before the write.
// - With transfer-on-clear, a clear during a buffer write moves the old value.
// - Capture in setup state: channel 1 reads old value, channel 5 reads captured.
// - Channel 1 capture in access state beats the CPU write.
// - Channel 5 write in access state wins, capture flag still sets.
// - Capture-driven buffer transfer beats a CPU write to the buffer register.
// - Lower counter write on wrap suppresses upper count, upper match still fires.
// - Channel 0 and channel 1 B still capture on the suppressed cascade event.
// - Complementary stop leaves counter 3 at dead time, counter 4 at zero.
// - Complementary restart begins from initial state; software reloads other modes.
// - Complementary with A pairing: C registers and carrier buffer feed their targets.
// - Reset-sync: channel 4 pairing set suppresses the ch4_out_c waveform.
// - Reset-sync buffering of both channels follows channel 3 pairing bits.
// - Flags C and D never set while those registers act as buffers.
// - Reset-sync runs both counters from ch3_run and channel 3 clock control.
// - Reset-sync clear on FFFF match clears both counters, no overflow flag.
// - Clear coinciding with overflow or underflow wins and sets no flag.
// - Counter write coinciding with wrap wins and sets no flag.
// - Counter clear in the write access state beats the written value.
// - A flag clears only by writing 0 after reading it as 1.
//
// Decided for this implementation: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module tac_timer #(
  parameter int DIV_W = 6
) (
  input  wire logic                         CLK,
  input  wire logic                         SRST,
  input  wire logic                         PSEL,
  input  wire logic                         PENABLE,
  input  wire logic                         PWRITE,
  input  wire logic [tac_pkg::ADDR_W-1:0]   PADDR,
  input  wire logic [tac_pkg::DATA_W-1:0]   PWDATA,
  output logic      [tac_pkg::DATA_W-1:0]   PRDATA,
  output logic                              PREADY,
  output logic                              PSLVERR,
  input  wire logic                         CAP1_IN,
  input  wire logic                         CAP5_IN,
  output logic                              OUT3_B,
  output logic                              OUT4_A,
  output logic                              CH4_OUT_C
);
  import tac_pkg::*;

  initial begin
    if (DIV_W < 6) $error("DIV_W must be at least 6");
  end

  function automatic logic rate_tick(input logic [1:0] sel, input logic [DIV_W-1:0] p);
    case (sel)
      2'h0:    rate_tick = 1'b1;
      2'h1:    rate_tick = &p[1:0];
      2'h2:    rate_tick = &p[3:0];
      default: rate_tick = &p[5:0];
    endcase
  endfunction

  logic [DIV_W-1:0]  pre_reg;
  logic [CTRL_W-1:0] ctrl_reg;
  logic [1:0]        clk3_reg, clk4_reg, mode3_reg, mode4_reg;
  logic [FLAG_W-1:0] flag_reg, seen_reg, flag_set, flag_clr;
  logic [CNT_W-1:0]  cnt3_reg, cnt4_reg, cnt2_reg, cnt1_reg, cnt0_reg, cnt5_reg;
  logic [CNT_W-1:0]  cc3a_reg, cc3b_reg, cc3c_reg, cc3d_reg, cc4a_reg, cc4c_reg;
  logic [CNT_W-1:0]  dead_reg, carr_reg, carrb_reg;
  logic [CNT_W-1:0]  cc1a_reg, cc1b_reg, cc1d_reg, cc0_reg, cc5_reg;
  logic [DATA_W-1:0] prdata_reg, rd_val;
  logic              dir_up_reg;
  logic              cap1_s1, cap1_s2, cap1_s3, cap5_s1, cap5_s2, cap5_s3;
  logic              out3_reg, out4a_reg, out4c_reg;

  logic              setup_c, acc_c, wr_c, hit_c;
  logic [CNT_W-1:0]  wd;
  tac_mode_t         mode;
  logic              pair, run3, bfa3, bfb3, bfa4, tick3, tick4, tick2;
  logic              peak, trough, match3a, clr3, ovf3, udf4, xfer3, xfer4;
  logic              wrap2, casc_evt, cap1, cap5;
  logic [CNT_W-1:0]  pwm_base;

  // Two bus states: setup (T1) then a zero-wait access (T2)
  assign setup_c = PSEL && !PENABLE;
  assign acc_c   = PSEL && PENABLE;
  assign wr_c    = acc_c && PWRITE && hit_c;
  assign wd      = PWDATA[CNT_W-1:0];
  assign PREADY  = 1'b1;
  assign PSLVERR = acc_c && !hit_c;
  assign PRDATA  = prdata_reg;

  function automatic logic wr_at(input logic w, input logic [ADDR_W-1:0] a,
                                 input logic [ADDR_W-1:0] off);
    wr_at = w && (a == off);
  endfunction

  assign mode = tac_mode_t'(ctrl_reg[CTL_MODE +: 2]);
  assign pair = (mode == TAC_COMPL) || (mode == TAC_RSYNC);
  assign run3 = ctrl_reg[CTL_RUN3];
  assign bfa3 = mode3_reg[MD_BFA];
  assign bfb3 = mode3_reg[MD_BFB];
  // Paired modes take channel 4 buffering from channel 3
  assign bfa4 = pair ? bfa3 : mode4_reg[MD_BFA];

  // Channel 4 shares channel 3 start and clock in paired modes
  assign tick3 = run3 && rate_tick(clk3_reg, pre_reg);
  assign tick4 = pair ? tick3 : (ctrl_reg[CTL_RUN4] && rate_tick(clk4_reg, pre_reg));
  assign tick2 = ctrl_reg[CTL_RUN2] && rate_tick(clk3_reg, pre_reg);

  assign peak    = (mode == TAC_COMPL) && dir_up_reg && (cnt3_reg == carr_reg);
  assign trough  = (mode == TAC_COMPL) && !dir_up_reg && (cnt4_reg == CNT_ZERO);
  assign match3a = tick3 && (mode != TAC_COMPL) && (cnt3_reg == cc3a_reg);
  assign clr3    = match3a && ctrl_reg[CTL_CLR3];
  // Clear and counter write both mask the wrap flags
  assign ovf3 = tick3 && (mode != TAC_COMPL) && (cnt3_reg == CNT_MAX) && !clr3
                && !wr_at(wr_c, PADDR, OFF_CNT3);
  assign udf4 = tick3 && trough && !wr_at(wr_c, PADDR, OFF_CNT4);
  assign xfer3 = (mode == TAC_COMPL) ? (tick3 && peak)
               : (ctrl_reg[CTL_BTM] ? clr3 : match3a);
  assign xfer4 = pair ? xfer3 : (tick4 && (cnt4_reg == cc4a_reg));

  assign wrap2    = tick2 && (cnt2_reg == CNT_MAX);
  assign casc_evt = wrap2 && ctrl_reg[CTL_CASC];
  // Only the synchroniser's second stage and its delayed copy feed the edges
  assign cap1 = (cap1_s2 && !cap1_s3) || (ctrl_reg[CTL_CAP1B] && casc_evt);
  assign cap5 = cap5_s2 && !cap5_s3;

  always_ff @(posedge CLK) begin
    if (SRST) begin
      cap1_s1 <= 1'b0;
      cap1_s2 <= 1'b0;
      cap1_s3 <= 1'b0;
      cap5_s1 <= 1'b0;
      cap5_s2 <= 1'b0;
      cap5_s3 <= 1'b0;
    end else begin
      cap1_s1 <= CAP1_IN;
      cap1_s2 <= cap1_s1;
      cap1_s3 <= cap1_s2;
      cap5_s1 <= CAP5_IN;
      cap5_s2 <= cap5_s1;
      cap5_s3 <= cap5_s2;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) pre_reg <= '0;
    else pre_reg <= pre_reg + 1'b1;
  end

  // Plain configuration registers
  always_ff @(posedge CLK) begin
    if (SRST) begin
      ctrl_reg  <= '0;
      clk3_reg  <= '0;
      clk4_reg  <= '0;
      mode3_reg <= '0;
      mode4_reg <= '0;
      dead_reg  <= CNT_ZERO;
      carrb_reg <= RST_CC;
      cc3c_reg  <= RST_CC;
      cc3d_reg  <= RST_CC;
      cc4c_reg  <= RST_CC;
      cc1a_reg  <= RST_CC;
    end else begin
      if (wr_at(wr_c, PADDR, OFF_CTRL))  ctrl_reg  <= PWDATA[CTRL_W-1:0];
      if (wr_at(wr_c, PADDR, OFF_CLK3))  clk3_reg  <= PWDATA[1:0];
      if (wr_at(wr_c, PADDR, OFF_CLK4))  clk4_reg  <= PWDATA[1:0];
      if (wr_at(wr_c, PADDR, OFF_MODE3)) mode3_reg <= PWDATA[1:0];
      if (wr_at(wr_c, PADDR, OFF_MODE4)) mode4_reg <= PWDATA[1:0];
      if (wr_at(wr_c, PADDR, OFF_DEAD))  dead_reg  <= wd;
      if (wr_at(wr_c, PADDR, OFF_CARRB)) carrb_reg <= wd;
      // Buffer writes land even when a transfer reads the old value
      if (wr_at(wr_c, PADDR, OFF_CC3C))  cc3c_reg  <= wd;
      if (wr_at(wr_c, PADDR, OFF_CC3D))  cc3d_reg  <= wd;
      if (wr_at(wr_c, PADDR, OFF_CC4C))  cc4c_reg  <= wd;
      if (wr_at(wr_c, PADDR, OFF_CC1A))  cc1a_reg  <= wd;
    end
  end

  // Complementary count direction; stopping rearms the initial state
  always_ff @(posedge CLK) begin
    if (SRST || !run3 || mode != TAC_COMPL) dir_up_reg <= 1'b1;
    else if (tick3 && peak) dir_up_reg <= 1'b0;
    else if (tick3 && trough) dir_up_reg <= 1'b1;
  end

  always_ff @(posedge CLK) begin
    if (SRST) cnt3_reg <= CNT_ZERO;
    else if (mode == TAC_COMPL) begin
      if (!run3) cnt3_reg <= dead_reg;
      else if (wr_at(wr_c, PADDR, OFF_CNT3)) cnt3_reg <= wd;
      else if (tick3 && !peak && !trough)
        cnt3_reg <= dir_up_reg ? cnt3_reg + 1'b1 : cnt3_reg - 1'b1;
    end else if (clr3) cnt3_reg <= CNT_ZERO;
    else if (wr_at(wr_c, PADDR, OFF_CNT3)) cnt3_reg <= wd;
    else if (tick3) cnt3_reg <= cnt3_reg + 1'b1;
  end

  always_ff @(posedge CLK) begin
    if (SRST) cnt4_reg <= CNT_ZERO;
    else if (mode == TAC_COMPL) begin
      if (!run3) cnt4_reg <= CNT_ZERO;
      else if (wr_at(wr_c, PADDR, OFF_CNT4)) cnt4_reg <= wd;
      else if (tick3 && !peak && !trough)
        cnt4_reg <= dir_up_reg ? cnt4_reg + 1'b1 : cnt4_reg - 1'b1;
    end else if (mode == TAC_RSYNC && clr3) cnt4_reg <= CNT_ZERO;
    else if (wr_at(wr_c, PADDR, OFF_CNT4)) cnt4_reg <= wd;
    else if (tick4) cnt4_reg <= cnt4_reg + 1'b1;
  end

  // Buffer targets: a CPU write to the target itself takes its value
  always_ff @(posedge CLK) begin
    if (SRST) begin
      cc3a_reg <= RST_CC;
      cc3b_reg <= RST_CC;
      cc4a_reg <= RST_CC;
      carr_reg <= RST_CC;
    end else begin
      if (wr_at(wr_c, PADDR, OFF_CC3A)) cc3a_reg <= wd;
      else if (xfer3 && bfa3) cc3a_reg <= cc3c_reg;
      if (wr_at(wr_c, PADDR, OFF_CC3B)) cc3b_reg <= wd;
      else if (xfer3 && bfb3) cc3b_reg <= cc3d_reg;
      if (wr_at(wr_c, PADDR, OFF_CC4A)) cc4a_reg <= wd;
      else if (xfer4 && bfa4) cc4a_reg <= cc4c_reg;
      if (wr_at(wr_c, PADDR, OFF_CARR)) carr_reg <= wd;
      else if (mode == TAC_COMPL && xfer3 && bfa3) carr_reg <= carrb_reg;
    end
  end

  // Cascade pair: lower counter 2 carries into upper counter 1
  always_ff @(posedge CLK) begin
    if (SRST) begin
      cnt2_reg <= CNT_ZERO;
      cnt1_reg <= CNT_ZERO;
    end else begin
      if (wr_at(wr_c, PADDR, OFF_CNT2)) cnt2_reg <= wd;
      else if (tick2) cnt2_reg <= cnt2_reg + 1'b1;
      if (wr_at(wr_c, PADDR, OFF_CNT1)) cnt1_reg <= wd;
      else if (casc_evt && !wr_at(wr_c, PADDR, OFF_CNT2))
        cnt1_reg <= cnt1_reg + 1'b1;
    end
  end

  // Reference counters for channels 0 and 5 run on every clock
  always_ff @(posedge CLK) begin
    if (SRST) begin
      cnt0_reg <= CNT_ZERO;
      cnt5_reg <= CNT_ZERO;
    end else begin
      cnt0_reg <= cnt0_reg + 1'b1;
      cnt5_reg <= cnt5_reg + 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      cc1b_reg <= RST_CC;
      cc1d_reg <= RST_CC;
      cc0_reg  <= RST_CC;
      cc5_reg  <= RST_CC;
    end else begin
      if (cap1) cc1b_reg <= cnt1_reg;
      else if (wr_at(wr_c, PADDR, OFF_CC1B)) cc1b_reg <= wd;
      if (cap1 && ctrl_reg[CTL_BUF1]) cc1d_reg <= cc1b_reg;
      else if (wr_at(wr_c, PADDR, OFF_CC1D)) cc1d_reg <= wd;
      if (casc_evt && ctrl_reg[CTL_CAP0]) cc0_reg <= cnt0_reg;
      else if (wr_at(wr_c, PADDR, OFF_CC0)) cc0_reg <= wd;
      if (wr_at(wr_c, PADDR, OFF_CC5)) cc5_reg <= wd;
      else if (cap5) cc5_reg <= cnt5_reg;
    end
  end

  always_comb begin
    flag_set = '0;
    flag_set[FL_OVF]  = ovf3;
    flag_set[FL_UDF]  = udf4;
    flag_set[FL_CMPA] = match3a || (tick3 && peak);
    flag_set[FL_CMPC] = tick3 && (cnt3_reg == cc3c_reg) && !bfa3;
    flag_set[FL_CMPD] = tick3 && (cnt3_reg == cc3d_reg) && !bfb3;
    flag_set[FL_C1A]  = casc_evt && (cnt1_reg == cc1a_reg);
    flag_set[FL_C1B]  = cap1;
    flag_set[FL_CAP5] = cap5;
    flag_set[FL_OVF2] = wrap2 && !wr_at(wr_c, PADDR, OFF_CNT2);
  end

  // Only bits seen as 1 by a read may be cleared by a 0
  assign flag_clr = wr_at(wr_c, PADDR, OFF_FLAGS) ?
                    (~PWDATA[FLAG_W-1:0] & seen_reg) : '0;

  always_ff @(posedge CLK) begin
    if (SRST) begin
      flag_reg <= '0;
      seen_reg <= '0;
    end else begin
      // A new event in the clearing cycle survives
      flag_reg <= (flag_reg & ~flag_clr) | flag_set;
      if (setup_c && !PWRITE && PADDR == OFF_FLAGS) seen_reg <= flag_reg;
      else seen_reg <= seen_reg & ~flag_clr;
    end
  end

  always_comb begin
    hit_c  = 1'b1;
    rd_val = RD_ZERO;
    case (PADDR)
      OFF_CTRL:  rd_val[CTRL_W-1:0] = ctrl_reg;
      OFF_CLK3:  rd_val[1:0] = clk3_reg;
      OFF_CLK4:  rd_val[1:0] = clk4_reg;
      OFF_MODE3: rd_val[1:0] = mode3_reg;
      OFF_MODE4: rd_val[1:0] = mode4_reg;
      OFF_FLAGS: rd_val[FLAG_W-1:0] = flag_reg;
      OFF_CNT3:  rd_val[CNT_W-1:0] = cnt3_reg;
      OFF_CNT4:  rd_val[CNT_W-1:0] = cnt4_reg;
      OFF_CC3A:  rd_val[CNT_W-1:0] = cc3a_reg;
      OFF_CC3B:  rd_val[CNT_W-1:0] = cc3b_reg;
      OFF_CC3C:  rd_val[CNT_W-1:0] = cc3c_reg;
      OFF_CC3D:  rd_val[CNT_W-1:0] = cc3d_reg;
      OFF_CC4A:  rd_val[CNT_W-1:0] = cc4a_reg;
      OFF_CC4C:  rd_val[CNT_W-1:0] = cc4c_reg;
      OFF_DEAD:  rd_val[CNT_W-1:0] = dead_reg;
      OFF_CARR:  rd_val[CNT_W-1:0] = carr_reg;
      OFF_CARRB: rd_val[CNT_W-1:0] = carrb_reg;
      OFF_CNT2:  rd_val[CNT_W-1:0] = cnt2_reg;
      OFF_CNT1:  rd_val[CNT_W-1:0] = cnt1_reg;
      OFF_CC1A:  rd_val[CNT_W-1:0] = cc1a_reg;
      OFF_CC1B:  rd_val[CNT_W-1:0] = cc1b_reg;
      OFF_CC1D:  rd_val[CNT_W-1:0] = cc1d_reg;
      OFF_CC0:   rd_val[CNT_W-1:0] = cc0_reg;
      OFF_CC5:   rd_val[CNT_W-1:0] = cap5 ? cnt5_reg : cc5_reg;
      default:   hit_c = 1'b0;
    endcase
  end

  // Read data is frozen in the setup state and held through the access
  always_ff @(posedge CLK) begin
    if (SRST) prdata_reg <= RD_ZERO;
    else if (setup_c && !PWRITE) prdata_reg <= rd_val;
  end

  // Paired modes compare channel 4 duty against the shared counter
  assign pwm_base = pair ? cnt3_reg : cnt4_reg;

  always_ff @(posedge CLK) begin
    if (SRST) begin
      out3_reg  <= 1'b0;
      out4a_reg <= 1'b0;
      out4c_reg <= 1'b0;
    end else begin
      out3_reg  <= cnt3_reg < cc3b_reg;
      out4a_reg <= pwm_base < cc4a_reg;
      if (mode == TAC_RSYNC && mode4_reg[MD_BFA]) out4c_reg <= 1'b0;
      else if (pair) out4c_reg <= !(pwm_base < cc4a_reg);
      else out4c_reg <= cnt4_reg < cc4c_reg;
    end
  end

  assign OUT3_B    = out3_reg;
  assign OUT4_A    = out4a_reg;
  assign CH4_OUT_C = out4c_reg;
endmodule // tac_timer
`default_nettype wire

// ==== verif/tac_timer_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module tac_timer_checker (
  input wire logic                       CLK,
  input wire logic                       SRST,
  input wire logic                       PSEL,
  input wire logic                       PENABLE,
  input wire logic                       PWRITE,
  input wire logic [tac_pkg::ADDR_W-1:0] PADDR,
  input wire logic [tac_pkg::DATA_W-1:0] PWDATA,
  input wire logic [tac_pkg::DATA_W-1:0] PRDATA,
  input wire logic                       PREADY,
  input wire logic                       PSLVERR,
  input wire logic                       CAP1_IN,
  input wire logic                       CAP5_IN,
  input wire logic                       OUT3_B,
  input wire logic                       OUT4_A,
  input wire logic                       CH4_OUT_C
);
  import tac_pkg::*;
  logic [1:0]  mode_q;
  logic        run_q;
  logic        pair4_q;
  logic [15:0] dead_q;
  logic [3:0]  quiet_q;
  wire logic   wr_acc = PSEL && PENABLE && PWRITE;
  wire logic   rd_acc = PSEL && PENABLE && !PWRITE;

  // Shadow of committed configuration so mode-dependent checks need no internals
  always_ff @(posedge CLK) begin
    if (SRST) begin
      mode_q <= 2'h0;
      run_q  <= 1'b0;
    end else if (wr_acc && PADDR == OFF_CTRL) begin
      mode_q <= PWDATA[CTL_MODE+:2];
      run_q  <= PWDATA[CTL_RUN3];
    end
  end
  always_ff @(posedge CLK) begin
    if (SRST)
      pair4_q <= 1'b0;
    else if (wr_acc && PADDR == OFF_MODE4)
      pair4_q <= PWDATA[MD_BFA];
  end
  always_ff @(posedge CLK) begin
    if (SRST)
      dead_q <= CNT_ZERO;
    else if (wr_acc && PADDR == OFF_DEAD)
      dead_q <= PWDATA[15:0];
  end
  // Cycles since the last write, so registered outputs have had time to follow
  always_ff @(posedge CLK) begin
    if (SRST || wr_acc)
      quiet_q <= 4'h0;
    else if (quiet_q != 4'hF)
      quiet_q <= quiet_q + 4'h1;
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);

  a_ready_high: assert property (PREADY)
    else $error("ready not high");
  a_err_access: assert property (!(PSEL && PENABLE) |-> !PSLVERR)
    else $error("error flag outside access");
  a_err_unmapped: assert property (
    PSEL && PENABLE && PADDR > OFF_CC5 |-> PSLVERR && (PWRITE || PRDATA == RD_ZERO))
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (
    PSEL && PENABLE && PADDR <= OFF_CC5 && PADDR[1:0] == 2'h0 |-> !PSLVERR)
    else $error("mapped access refused");
  a_rdata_hold: assert property (!$past(PSEL) && !$past(SRST) |-> $stable(PRDATA))
    else $error("read data moved without setup");
  a_upper_zero: assert property (rd_acc |-> PRDATA[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  a_ch4c_forced: assert property (
    mode_q == 2'h2 && pair4_q && quiet_q > 4'h1 |-> !CH4_OUT_C)
    else $error("ch4 out c driven while suppressed");
  a_compl_stop: assert property (
    mode_q == 2'h1 && !run_q && quiet_q > 4'h3 && rd_acc
    && (PADDR == OFF_CNT3 || PADDR == OFF_CNT4)
    |-> PRDATA[15:0] == (PADDR == OFF_CNT3 ? dead_q : CNT_ZERO))
    else $error("stopped counters not at initial values");

  c_refused: cover property (PSEL && PENABLE && PSLVERR);
  c_forced: cover property (mode_q == 2'h2 && pair4_q && quiet_q > 4'h1);
  c_stopped: cover property (mode_q == 2'h1 && !run_q && rd_acc);
endmodule // tac_timer_checker

bind tac_timer tac_timer_checker u_chk (
  .CLK(CLK), .SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .CAP1_IN(CAP1_IN), .CAP5_IN(CAP5_IN), .OUT3_B(OUT3_B),
  .OUT4_A(OUT4_A), .CH4_OUT_C(CH4_OUT_C));
`default_nettype wire

// ==== verif/tac_cpu_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module tac_cpu_model (
  input  wire logic                       clk,
  input  wire logic                       pready,
  output logic                            psel,
  output logic                            penable,
  output logic                            pwrite,
  output logic [tac_pkg::ADDR_W-1:0]      paddr,
  output logic [tac_pkg::DATA_W-1:0]      pwdata
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end
  // Without last the bus stays selected so the next setup follows at once
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic last);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    if (last) begin
      psel    <= 1'b0;
      penable <= 1'b0;
      paddr   <= ~a;
      pwdata  <= ~d;
      @(posedge clk);
    end
  endtask
endmodule // tac_cpu_model
`default_nettype wire

// ==== verif/timer_access_contention_logic_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module timer_access_contention_logic_test;
  import tac_pkg::*;
  localparam logic [32:0] ALL = 33'h1_FFFF_FFFF;
  localparam logic [7:0]  BUFR [5] = '{OFF_CC3A, OFF_CC3C, OFF_CC3D, OFF_CARR, OFF_CARRB};
  logic        clk;
  logic        srst;
  logic        cap1;
  logic        cap5;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        out3b;
  logic        out4a;
  logic        ch4c;
  int          miscompares;
  int          check_count;
  logic [31:0] lfsr;
  logic [31:0] v;
  logic [32:0] exp_q[$];
  logic [32:0] msk_q[$];

  tac_cpu_model cpu (.clk(clk), .pready(pready), .psel(psel), .penable(penable),
                     .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  tac_timer #(.DIV_W(6)) DUT (
    .CLK(clk), .SRST(srst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .CAP1_IN(cap1), .CAP5_IN(cap5), .OUT3_B(out3b),
    .OUT4_A(out4a), .CH4_OUT_C(ch4c));

  always #12.5 clk = ~clk;

  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction

  task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    if (miscompares == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic last = 1'b1);
    cpu.xfer(1'b1, a, d, last);
  endtask

  task automatic rd(input logic [7:0] a, input logic [32:0] e, input logic [32:0] m);
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    cpu.xfer(1'b0, a, rnd(), 1'b1);
  endtask

  // Each read access retires the oldest note; the error flag rides in bit 32
  always @(posedge clk) begin : monitor
    logic [32:0] m;
    if (psel && penable && !pwrite && pready === 1'b1) begin
      if (exp_q.size() == 0)
        check("read note", 33'h0, ALL);
      else begin
        m = msk_q.pop_front();
        check("read data", {pslverr, prdata} & m, exp_q.pop_front());
      end
    end
  end

  initial begin : watchdog
    repeat (6000) @(posedge clk);
    miscompares++;
    conclude();
  end

  initial begin
    clk = 1'b0;
    srst = 1'b1;
    cap1 = 1'b0;
    cap5 = 1'b0;
    lfsr = 32'h6786B01D;
    miscompares = 0;
    check_count = 0;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rd(8'h60, {1'b1, RD_ZERO}, ALL);
    rd(OFF_CC3A, {17'h0, RST_CC}, ALL);
    rd(OFF_CTRL, 33'h0, ALL);
    wr(OFF_CLK4, 32'h3);
    wr(OFF_CTRL, 32'h1);
    // Counter ticks every clock, so every counter write meets an increment
    v = rnd() & 32'h7FFF;
    wr(OFF_CNT3, v, 1'b0);
    rd(OFF_CNT3, {1'b0, v}, ALL);
    wr(OFF_CNT3, 32'hFFFE, 1'b0);
    wr(OFF_CNT3, v, 1'b0);
    rd(OFF_CNT3, {1'b0, v}, ALL);
    rd(OFF_FLAGS, 33'h0, 33'h1);
    // Wrap meets a clear on the FFFF match, in normal then reset-sync mode
    for (int m = 0; m < 4; m += 2) begin
      wr(OFF_CTRL, 32'h0);
      wr(OFF_CNT3, 32'hFFF0);
      wr(OFF_CNT4, 32'hFFF0);
      wr(OFF_CTRL, (32'(m) << CTL_MODE) | (m == 0 ? 32'h441 : 32'h41));
      repeat (40) @(posedge clk);
      rd(OFF_FLAGS, 33'h0, 33'h1);
      rd(OFF_CNT3, 33'h0, 33'hFFC0);
      if (m == 2)
        rd(OFF_CNT4, 33'h0, 33'hFFC0);
    end
    v = rnd() & 32'hFF;
    wr(OFF_CTRL, 32'h0);
    wr(OFF_DEAD, v);
    wr(OFF_CARR, 32'h0100);
    wr(OFF_CTRL, 32'h9);
    repeat (30) @(posedge clk);
    wr(OFF_CTRL, 32'h8);
    repeat (3) @(posedge clk);
    rd(OFF_CNT3, {1'b0, v}, ALL);
    rd(OFF_CNT4, 33'h0, ALL);
    wr(OFF_CTRL, 32'h9, 1'b0);
    rd(OFF_CNT4, 33'h0, 33'hFFF0);
    wr(OFF_CTRL, 32'h0);
    rd(OFF_FLAGS, 33'h0, 33'h0);
    wr(OFF_FLAGS, 32'h0);
    wr(OFF_MODE3, 32'h3);
    wr(OFF_DEAD, 32'h2);
    for (int m = 1; m < 3; m++) begin
      wr(OFF_CTRL, 32'h0);
      wr(OFF_CNT3, 32'h2);
      wr(OFF_CNT4, 32'h0);
      foreach (BUFR[i])
        wr(BUFR[i], 32'h20);
      v = rnd() & 32'h1F;
      wr(OFF_CC4C, v);
      wr(OFF_CTRL, (32'(m) << CTL_MODE) | (m == 2 ? 32'h41 : 32'h1));
      repeat (100) @(posedge clk);
      rd(OFF_CC4A, {1'b0, v}, ALL);
      rd(OFF_FLAGS, 33'h0, 33'h18);
    end
    wr(OFF_MODE4, 32'h1);
    repeat (3) @(posedge clk);
    repeat (40) begin
      @(posedge clk);
      check("ch4 out c", {32'h0, ch4c}, 33'h0);
    end
    wr(OFF_MODE4, 32'h0);
    // Cascade with no clear source on either counter, so both stay in step
    wr(OFF_CTRL, 32'h6);
    wr(OFF_CNT2, 32'hFFFE, 1'b0);
    // Second write lands on the lower counter's wrap
    wr(OFF_CNT2, 32'h0010, 1'b0);
    rd(OFF_CNT1, 33'h0, ALL);
    rd(OFF_FLAGS, 33'h0, 33'h100);
    cap1 <= 1'b1;
    cap5 <= 1'b1;
    repeat (4) @(posedge clk);
    cap1 <= 1'b0;
    cap5 <= 1'b0;
    repeat (6) @(posedge clk);
    // A clear that was not preceded by a read of the set flag must not take
    wr(OFF_FLAGS, 32'h0);
    rd(OFF_FLAGS, 33'hC0, 33'hC0);
    wr(OFF_FLAGS, 32'h0);
    rd(OFF_FLAGS, 33'h0, 33'hC0);
    check("notes left", {1'b0, 32'(exp_q.size())}, 33'h0);
    conclude();
  end
endmodule // timer_access_contention_logic_test
`default_nettype wire
